// File: verilog/asc_pkg.sv
// Shared constants, field layouts and types for the converter sequencer.
// Assumes a 32-bit AXI4-Lite register bus and an analog core on one clock.
`default_nettype none

package asc_pkg;

   // Register byte offsets
   localparam logic [4:0] OFF_STATUS = 5'h00;
   localparam logic [4:0] OFF_CTL1 = 5'h04;
   localparam logic [4:0] OFF_CTL2 = 5'h08;
   localparam logic [4:0] OFF_CTL3 = 5'h0C;
   localparam logic [4:0] OFF_RES0 = 5'h10;
   localparam logic [4:0] OFF_RES1 = 5'h14;
   localparam logic [4:0] OFF_RES2 = 5'h18;
   localparam logic [4:0] OFF_RES3 = 5'h1C;

   // Field positions
   localparam int CTL1_EN_BIT = 0;
   localparam int CTL1_IE_BIT = 2;
   localparam int ST_OVF_BIT = 2;

   // Reset and load values
   localparam logic [1:0] PTR_RESET = 2'h3;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // Conversion length in converter clock ticks
   localparam int CONV_TICKS = 10;

   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Scan select encodings
   localparam logic [1:0] SCAN_SINGLE = 2'h0;
   localparam logic [1:0] SCAN_FOUR = 2'h1;

   // Register identities after decode
   typedef enum {
      REG_STATUS, REG_CTL1, REG_CTL2, REG_CTL3,
      REG_RES0, REG_RES1, REG_RES2, REG_RES3, REG_NONE
   } asc_reg_id_type;

   // Mode and start register layout
   typedef struct packed {
      logic start;
      logic [1:0] scan;
      logic repeat_select;
      logic [3:0] channel;
   } asc_ctl2_type;

   // Clock and delay register layout
   typedef struct packed {
      logic [1:0] rsv;
      logic [2:0] delay;
      logic [2:0] clock_divide_field;
   } asc_ctl3_type;

   // Strobes and channel towards the analog core
   typedef struct packed {
      logic sample;
      logic convert;
      logic [2:0] channel;
   } asc_core_ctl_type;

   // Address to register identity
   function automatic asc_reg_id_type asc_decode(input logic [4:0] addr);
      case (addr)
         OFF_STATUS: asc_decode = REG_STATUS;
         OFF_CTL1: asc_decode = REG_CTL1;
         OFF_CTL2: asc_decode = REG_CTL2;
         OFF_CTL3: asc_decode = REG_CTL3;
         OFF_RES0: asc_decode = REG_RES0;
         OFF_RES1: asc_decode = REG_RES1;
         OFF_RES2: asc_decode = REG_RES2;
         OFF_RES3: asc_decode = REG_RES3;
         default: asc_decode = REG_NONE;
      endcase
   endfunction

endpackage

`default_nettype wire

// File: verilog/asc_prescaler.sv
// Free-running prescaler that marks each converter clock as a one-cycle tick.
// Assumes the divide code is held steady while the converter is enabled.
`default_nettype none

module asc_prescaler (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Divide code in, tick out
   input wire logic [2:0] divide_code,
   output logic tick
);
   import asc_pkg::*;

   logic [4:0] count_reg; // Free-running count
   logic [4:0] mask;      // Low bits that must be all ones

   // Divide code to count mask; reserved codes fall back to the slowest rate
   always_comb begin
      case (divide_code)
         3'h0: mask = 5'h00;
         3'h1: mask = 5'h01;
         3'h2: mask = 5'h03;
         3'h3: mask = 5'h07;
         3'h4: mask = 5'h0F;
         default: mask = 5'h1F;
      endcase
   end

   // tick from counter
   // Counter never stops, so there is no separate clock domain
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 5'h00;
      end else begin
         count_reg <= count_reg + 5'h01;
      end
   end

   assign tick = ((count_reg & mask) == mask);

endmodule

`default_nettype wire

// File: verilog/asc_engine.sv
// Timing of one conversion: sample, programmable delay, then ten ticks.
// Assumes the analog core holds its code valid when the convert phase ends.
`default_nettype none

module asc_engine (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Converter clock tick and control
   input wire logic tick,
   input wire logic abort,
   input wire logic go,
   input wire logic [2:0] channel,
   input wire logic [2:0] delay_code,
   // Analog core link
   output asc_pkg::asc_core_ctl_type core_ctl,
   input wire logic [7:0] core_code,
   // Finished result
   output logic done,
   output logic [7:0] code
);
   import asc_pkg::*;

   typedef enum {ENG_IDLE, ENG_DELAY, ENG_CONV} asc_eng_state_type;

   asc_eng_state_type state_reg; // Phase of the conversion
   logic [6:0] cnt_reg;          // Ticks left in the phase, minus one
   logic [6:0] delay_load;       // Delay length minus one

   always_comb begin
      case (delay_code)
         3'h0: delay_load = 7'h00;
         3'h1: delay_load = 7'h01;
         3'h2: delay_load = 7'h03;
         3'h3: delay_load = 7'h07;
         3'h4: delay_load = 7'h0F;
         3'h5: delay_load = 7'h1F;
         default: delay_load = 7'h3F;
      endcase
   end

   // Phase sequencing and strobes to the core
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ENG_IDLE;
         cnt_reg <= 7'h00;
         core_ctl <= '0;
         done <= 1'b0;
         code <= BYTE_ZERO;
      end else begin
         core_ctl.sample <= 1'b0;
         core_ctl.convert <= 1'b0;
         done <= 1'b0;
         if (abort) begin
            state_reg <= ENG_IDLE;
         end else begin
            case (state_reg)
               ENG_IDLE: begin
                  // Sample the selected input
                  if (go) begin
                     core_ctl.sample <= 1'b1;
                     core_ctl.channel <= channel;
                     cnt_reg <= delay_load;
                     state_reg <= ENG_DELAY;
                  end
               end
               ENG_DELAY: begin
                  if (tick) begin
                     if (cnt_reg == 7'h00) begin
                        core_ctl.convert <= 1'b1;
                        cnt_reg <= 7'(CONV_TICKS - 1);
                        state_reg <= ENG_CONV;
                     end else begin
                        cnt_reg <= cnt_reg - 7'h01;
                     end
                  end
               end
               ENG_CONV: begin
                  if (tick) begin
                     if (cnt_reg == 7'h00) begin
                        done <= 1'b1;
                        code <= core_code;
                        state_reg <= ENG_IDLE;
                     end else begin
                        cnt_reg <= cnt_reg - 7'h01;
                     end
                  end
               end
               default: begin
                  state_reg <= ENG_IDLE;
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// File: verilog/asc_top.sv
// Converter sequencer: AXI4-Lite registers, mode sequencing, result slots.
// Assumes an analog core that samples and converts on the strobes given.
`default_nettype none

module asc_top (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // AXI4-Lite write address
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Analog core link
   output asc_pkg::asc_core_ctl_type core_ctl,
   input wire logic [7:0] core_code,
   // Converter interrupt
   output logic conv_irq
);
   import asc_pkg::*;

   typedef enum {SEQ_IDLE, SEQ_RUN} asc_seq_state_type;

   // Bus holding registers
   logic aw_hold_reg;
   logic [4:0] aw_addr_reg;
   logic w_hold_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic do_write;               // Both halves held, response free
   logic wr_en;                  // Write reaches the low byte
   asc_reg_id_type wr_id;        // Target of the write
   logic [7:0] wbyte;            // Written byte
   logic rd_take;                // Read address taken this edge
   asc_reg_id_type rd_id;        // Target of the read
   logic rd_result;              // Read hits a result slot
   logic [3:0] rd_slot_hit;      // Which slot is read

   // Control and status state
   logic enable_reg;             // converter_enable_bit
   logic irq_en_reg;             // converter_irq_enable
   asc_ctl2_type ctl2_reg;       // Mode and start fields
   asc_ctl3_type ctl3_reg;       // Clock and delay fields
   logic start_q_reg;            // Start one cycle ago
   logic eoc_reg;                // End of conversion
   logic ovf_reg;                // result_overrun_flag
   logic irq_pend_reg;           // Interrupt pending
   logic [1:0] ptr_reg;          // last_written_pointer
   logic [7:0] result_reg [4];   // Result slots
   logic [3:0] full_reg;         // Slot holds unread data

   // Sequencer state
   asc_seq_state_type seq_reg;
   logic [1:0] k_reg;            // Conversion number in the group
   logic [2:0] base_reg;         // First channel of the group
   logic [2:0] chan_reg;         // Channel for the next conversion
   logic go_reg;                 // Launch pulse to the engine
   logic start_rise;
   logic store;                  // Result arrives this cycle
   logic [1:0] slot;             // Slot being written
   logic group_end;
   logic stop;
   logic eoc_set;
   logic tick;
   logic eng_done;
   logic [7:0] eng_code;

   // Converter clock tick
   asc_prescaler u_prescaler (
      .clk(clk),
      .rst_n(rst_n),
      .divide_code(ctl3_reg.clock_divide_field),
      .tick(tick)
   );

   // One conversion at a time
   asc_engine u_engine (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick),
      .abort(!enable_reg),
      .go(go_reg),
      .channel(chan_reg),
      .delay_code(ctl3_reg.delay),
      .core_ctl(core_ctl),
      .core_code(core_code),
      .done(eng_done),
      .code(eng_code)
   );

   // Bus handshakes: one write and one read outstanding
   assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
   assign wr_en = do_write && w_strb_reg[0];
   assign wr_id = asc_decode(aw_addr_reg);
   assign wbyte = w_data_reg[7:0];
   assign rd_take = s_axi_arvalid && s_axi_arready;
   assign rd_id = asc_decode(s_axi_araddr);

   // Read side effects on result slots
   always_comb begin
      rd_slot_hit = 4'h0;
      if (rd_take) begin
         case (rd_id)
            REG_RES0: rd_slot_hit = 4'h1;
            REG_RES1: rd_slot_hit = 4'h2;
            REG_RES2: rd_slot_hit = 4'h4;
            REG_RES3: rd_slot_hit = 4'h8;
            default: rd_slot_hit = 4'h0;
         endcase
      end
   end
   assign rd_result = (rd_slot_hit != 4'h0);

   // Write address and data capture, in either order, then response
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= 5'h00;
         w_hold_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_id == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read data path
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
         case (rd_id)
            REG_STATUS: s_axi_rdata[7:0] <=
               {2'h0, ptr_reg, 1'b0, ovf_reg, (seq_reg == SEQ_RUN), eoc_reg};
            REG_CTL1: s_axi_rdata[7:0] <= {5'h00, irq_en_reg, 1'b0, enable_reg};
            REG_CTL2: s_axi_rdata[7:0] <= ctl2_reg;
            REG_CTL3: s_axi_rdata[7:0] <= ctl3_reg;
            REG_RES0: s_axi_rdata[7:0] <= result_reg[0];
            REG_RES1: s_axi_rdata[7:0] <= result_reg[1];
            REG_RES2: s_axi_rdata[7:0] <= result_reg[2];
            REG_RES3: s_axi_rdata[7:0] <= result_reg[3];
            default: s_axi_rresp <= RESP_SLVERR;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // control reset to zero
   // Enable and interrupt enable; reserved bits are dropped
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         enable_reg <= 1'b0;
         irq_en_reg <= 1'b0;
      end else if (wr_en && wr_id == REG_CTL1) begin
         enable_reg <= wbyte[CTL1_EN_BIT];
         irq_en_reg <= wbyte[CTL1_IE_BIT];
      end
   end

   // Mode, channel and start
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl2_reg <= '0;
         start_q_reg <= 1'b0;
      end else begin
         start_q_reg <= ctl2_reg.start;
         if (wr_en && wr_id == REG_CTL2) begin
            ctl2_reg.channel <= wbyte[3:0];
            if (!ctl2_reg.start) begin
               ctl2_reg.scan <= wbyte[6:5];
               ctl2_reg.repeat_select <= wbyte[4];
            end
            ctl2_reg.start <= wbyte[7] && enable_reg;
         end
         if (store && stop && !ctl2_reg.repeat_select) begin
            ctl2_reg.start <= 1'b0;
         end
         if (!enable_reg) begin
            ctl2_reg.start <= 1'b0;
         end
      end
   end

   // Clock divide and sample delay
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl3_reg <= '0;
      end else if (wr_en && wr_id == REG_CTL3) begin
         ctl3_reg.delay <= wbyte[5:3];
         ctl3_reg.clock_divide_field <= wbyte[2:0];
      end
   end

   // Sequence decisions on each finished conversion
   assign start_rise = ctl2_reg.start && !start_q_reg;
   assign store = eng_done && (seq_reg == SEQ_RUN) && enable_reg;
   assign slot = ptr_reg + 2'h1;
   assign group_end = (ctl2_reg.scan == SCAN_FOUR) ? (k_reg == 2'h3)
                    : (!ctl2_reg.repeat_select || k_reg == 2'h3);
   assign stop = group_end ? (!ctl2_reg.repeat_select || !ctl2_reg.start)
               : ((ctl2_reg.scan != SCAN_FOUR) && !ctl2_reg.start);
   assign eoc_set = store && (group_end || stop);

   // Sequencer: launches conversions and walks channels
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seq_reg <= SEQ_IDLE;
         k_reg <= 2'h0;
         base_reg <= 3'h0;
         chan_reg <= 3'h0;
         go_reg <= 1'b0;
      end else begin
         go_reg <= 1'b0;
         if (!enable_reg) begin
            seq_reg <= SEQ_IDLE;
         end else begin
            case (seq_reg)
               SEQ_IDLE: begin
                  if (start_rise) begin
                     k_reg <= 2'h0;
                     base_reg <= ctl2_reg.channel[2:0];
                     chan_reg <= ctl2_reg.channel[2:0];
                     go_reg <= 1'b1;
                     seq_reg <= SEQ_RUN;
                  end
               end
               SEQ_RUN: begin
                  if (store) begin
                     if (stop) begin
                        seq_reg <= SEQ_IDLE;
                     end else begin
                        k_reg <= k_reg + 2'h1;
                        chan_reg <= (ctl2_reg.scan == SCAN_FOUR)
                                  ? base_reg + {1'b0, k_reg + 2'h1} : base_reg;
                        go_reg <= 1'b1;
                     end
                  end
               end
               default: begin
                  seq_reg <= SEQ_IDLE;
               end
            endcase
         end
      end
   end

   // slots filled in order
   // Full marks clear on read; a store in the same cycle wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result_reg <= '{default: BYTE_ZERO};
         full_reg <= 4'h0;
      end else begin
         full_reg <= full_reg & ~rd_slot_hit;
         if (store) begin
            result_reg[slot] <= eng_code;
            full_reg[slot] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_reg <= PTR_RESET;
      end else if (start_rise && seq_reg == SEQ_IDLE && enable_reg) begin
         ptr_reg <= PTR_RESET;
      end else if (store) begin
         ptr_reg <= slot;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         eoc_reg <= 1'b0;
      end else if (!enable_reg) begin
         eoc_reg <= 1'b0;
      end else if (eoc_set) begin
         eoc_reg <= 1'b1;
      end else if (rd_result) begin
         eoc_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ovf_reg <= 1'b0;
      end else if (!enable_reg) begin
         ovf_reg <= 1'b0;
      end else if (store && full_reg[slot]) begin
         ovf_reg <= 1'b1;
      end else if (wr_en && wr_id == REG_STATUS && wbyte[ST_OVF_BIT]) begin
         ovf_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_pend_reg <= 1'b0;
      end else if (!enable_reg) begin
         irq_pend_reg <= 1'b0;
      end else if (eoc_set) begin
         irq_pend_reg <= 1'b1;
      end else if (rd_result) begin
         irq_pend_reg <= 1'b0;
      end
   end

   assign conv_irq = irq_pend_reg && irq_en_reg;

endmodule

`default_nettype wire

// File: verification/asc_core_model.sv
// Analog core stand-in: catches the channel at sampling, returns a code.
// Assumes strobes from asc_top on the same clock.
`default_nettype none
module asc_core_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Strobes in, code out
   input wire asc_pkg::asc_core_ctl_type core_ctl,
   output logic [7:0] core_code
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] held_ch; // Channel caught at sampling
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         held_ch <= 3'h0;
         core_code <= 8'h5A;
      end else if (core_ctl.sample) begin
         held_ch <= core_ctl.channel;
         core_code <= ~core_code;
      end else if (core_ctl.convert) begin
         core_code <= {held_ch, 5'h0B};
      end
   end
endmodule
`default_nettype wire

// File: verification/asc_chk.sv
// Checker of read answers, interrupt drop and core strobes.
// Assumes it is bound to asc_top and sees only its ports.
`default_nettype none
module asc_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Read side of the bus
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Core link and interrupt
   input wire asc_pkg::asc_core_ctl_type core_ctl,
   input wire logic conv_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Result slot read taken
   wire logic slot_rd;
   assign slot_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr[4] && !s_axi_araddr[1:0];
   property p_rbyte; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
   a_rbyte: assert property (p_rbyte) else $error("read data above low byte");
   property p_irq_drop; slot_rd |-> ##2 !conv_irq; endproperty
   a_irq_drop: assert property (p_irq_drop) else $error("irq kept after read");
   property p_spulse; core_ctl.sample |=> !core_ctl.sample; endproperty
   a_spulse: assert property (p_spulse) else $error("sample not a pulse");
   property p_cpulse; core_ctl.convert |=> !core_ctl.convert; endproperty
   a_cpulse: assert property (p_cpulse) else $error("convert not a pulse");
   property p_apart; !(core_ctl.sample && core_ctl.convert); endproperty
   a_apart: assert property (p_apart) else $error("no delay before convert");
   property p_clen; core_ctl.convert |=> !core_ctl.sample [*8]; endproperty
   a_clen: assert property (p_clen) else $error("conversion cut short");
   property p_chold; core_ctl.convert |-> $stable(core_ctl.channel); endproperty
   a_chold: assert property (p_chold) else $error("channel moved in delay");
   property p_rhold; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_rhold: assert property (p_rhold) else $error("read answer kept after take");
endmodule
bind asc_top asc_chk u_chk (.clk, .rst_n, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .core_ctl, .conv_irq);
`default_nettype wire

// File: verification/adc_sequencer_control_tb_top.sv
// Bench for the converter sequencer: bus tasks and mode scenarios.
// Assumes asc_top, the checker bind and the core model are compiled first.
`default_nettype none
module adc_sequencer_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import asc_pkg::*;
   localparam int SETTLE = 25000; // Cycles of settling after enable
   logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, conv_irq;
   logic [4:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   asc_core_ctl_type core_ctl;
   logic [7:0] core_code;
   int miscompares, total_checks, cnt, gap;
   asc_top dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .core_ctl, .core_code, .conv_irq);
   asc_core_model u_core (.clk, .rst_n, .core_ctl, .core_code);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Cycles from sample strobe to convert strobe
   always @(negedge clk) begin
      cnt <= core_ctl.sample ? 0 : cnt + 1;
      if (core_ctl.convert) gap <= cnt + 1;
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic hang();
      chk(32'h0, 32'h1, "wait");
      conclude();
   endtask
   task automatic chk_irq(input logic e);
      @(negedge clk);
      chk({31'h0, conv_irq}, {31'h0, e}, "irq");
   endtask
   // Write: address and data offered together, each released when taken
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic aw, w, b;
      b = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 64 && !b; n++) begin
         @(negedge clk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge clk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (b) s_axi_bready <= 1'b0;
      end
      if (!b) hang();
   endtask
   task automatic rd(input logic [4:0] a);
      logic ar, r;
      r = 1'b0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 64 && !r; n++) begin
         @(negedge clk);
         ar = s_axi_arvalid && s_axi_arready;
         r = s_axi_rvalid;
         rv = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge clk);
         if (ar) s_axi_arvalid <= 1'b0;
         if (r) s_axi_rready <= 1'b0;
      end
      if (!r) hang();
   endtask
   // Poll status until the masked bits match
   task automatic wait_st(input logic [7:0] m, input logic [7:0] v);
      rd(OFF_STATUS);
      for (int n = 0; n < 300 && (rv[7:0] & m) !== v; n++) rd(OFF_STATUS);
      if ((rv[7:0] & m) !== v) hang();
   endtask
   initial begin
      rst_n = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rd(5'(4 * i));
         chk(rv, (i == 0) ? 32'h30 : 32'h0, "reset value");
      end
      wr(5'h02, 8'h00);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped");
      rd(5'h02);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped read");
      $display("test reset done");
      wr(OFF_CTL1, 8'h05);
      repeat (SETTLE) @(posedge clk);
      wr(OFF_CTL2, 8'h85);
      wait_st(8'h01, 8'h01);
      chk_irq(1'b1);
      rd(OFF_CTL2);
      chk(rv, 32'h05, "mode");
      rd(OFF_RES0);
      chk(rv, 32'hAB, "slot");
      chk_irq(1'b0);
      rd(OFF_STATUS);
      chk(rv, 32'h00, "status");
      $display("test single done");
      wr(OFF_CTL1, 8'h00);
      wr(OFF_CTL3, 8'h11);
      wr(OFF_CTL1, 8'h01);
      repeat (SETTLE) @(posedge clk);
      wr(OFF_CTL2, 8'hA6);
      wr(OFF_CTL2, 8'h90);
      rd(OFF_CTL2);
      chk(rv, 32'hA0, "mode held");
      wait_st(8'h03, 8'h01);
      chk_irq(1'b0);
      chk({31'h0, gap >= 7 && gap <= 8}, 32'h1, "delay");
      rd(OFF_CTL2);
      chk(rv, 32'h20, "mode");
      for (int i = 0; i < 4; i++) begin
         rd(5'(OFF_RES0 + 4 * i));
         chk(rv, {24'h0, 3'(6 + i), 5'h0B}, "slot");
      end
      rd(OFF_STATUS);
      chk(rv, 32'h30, "status");
      $display("test scan done");
      wr(OFF_CTL2, 8'h93);
      wait_st(8'h04, 8'h04);
      rd(OFF_CTL2);
      chk(rv, 32'h93, "mode run");
      wr(OFF_CTL2, 8'h13);
      wait_st(8'h02, 8'h00);
      rd(OFF_STATUS);
      chk(rv & 32'h05, 32'h05, "overrun");
      wr(OFF_STATUS, 8'h04);
      rd(OFF_STATUS);
      chk(rv & 32'h04, 32'h0, "overrun clear");
      rd(OFF_RES0);
      chk(rv, {24'h0, 3'h3, 5'h0B}, "repeat slot");
      wr(OFF_CTL2, 8'hB6);
      wait_st(8'h01, 8'h01);
      wr(OFF_CTL2, 8'h36);
      wait_st(8'h02, 8'h00);
      rd(OFF_RES0);
      chk(rv, {24'h0, 3'h6, 5'h0B}, "scan wrap");
      wr(OFF_CTL2, 8'h93);
      wait_st(8'h02, 8'h02);
      wr(OFF_CTL1, 8'h00);
      rd(OFF_STATUS);
      chk(rv & 32'h07, 32'h0, "flags");
      rd(OFF_CTL2);
      chk(rv & 32'h80, 32'h0, "start");
      $display("test repeat done");
      conclude();
   end
endmodule
`default_nettype wire
